//--- hdl/uart_receive_buffer_status.sv
// Purpose: Serial receive path from pin to buffered data and status
// Assumes: Async bit sampling and start qualification come from outside
// Notes:   Error flags have no write path, so software writes cannot touch them
`timescale 1ns/1ps
module uart_receive_buffer_status (
  // Clock and reset
  input  wire logic                 clk_in,
  input  wire logic                 rstn_in,
  // Configuration
  input  wire uart_rx_pkg::rx_cfg_t cfg_in,
  input  wire logic                 global_irq_enable_in,
  // Serial side
  input  wire logic                 rx_pin_in,
  input  wire logic                 ext_sync_clock_in,
  input  wire logic                 start_valid_in,
  input  wire logic                 sample_tick_in,
  // Processor side
  input  wire logic                 data_read_in,
  output logic               [7:0]  rx_data_port_out,
  output logic                      rx_ninth_bit_out,
  output logic                      frame_error_flag_out,
  output logic                      overrun_flag_out,
  output logic                      parity_error_flag_out,
  output logic                      rx_complete_flag_out,
  output logic                      rx_complete_irq_out,
  // Pin ownership and activity
  output logic                      pin_override_out,
  output logic                      rx_busy_out
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  uart_rx_pkg::rx_state_t state_q;
  uart_rx_pkg::rx_state_t state_d;
  uart_rx_pkg::rx_word_t  hold_word_q;
  uart_rx_pkg::rx_word_t  push_word;
  uart_rx_pkg::rx_word_t  head_word;

  logic [8:0] shift_q;
  logic [3:0] bit_cnt_q;
  logic [3:0] frame_bits_q;
  logic       par_bit_q;
  logic       par_en_q;
  logic       par_odd_q;
  logic       discard_q;
  logic       hold_q;
  logic       pend_ovr_q;
  logic       enable;
  logic       rx_level;
  logic       xck_rise;
  logic       bit_strobe;
  logic       start_seen;
  logic       start_take;
  logic       ovr_event;
  logic       stop_take;
  logic       capture;
  logic       fifo_ready;
  logic       fifo_valid;
  logic       push;
  logic       flush;
  logic [8:0] aligned;
  logic       par_err;
  logic [11:0] fifo_out;

  // ----------------------------------------------------------------
  // Pin conditioning
  // ----------------------------------------------------------------
  rx_pin_sync u_rx_sync (
    .clk_in    (clk_in),
    .rstn_in   (rstn_in),
    .pin_in    (rx_pin_in),
    .level_out (rx_level),
    .rise_out  ()
  );

  rx_pin_sync u_xck_sync (
    .clk_in    (clk_in),
    .rstn_in   (rstn_in),
    .pin_in    (ext_sync_clock_in),
    .level_out (),
    .rise_out  (xck_rise)
  );

  assign enable           = cfg_in.receiver_enable;
  assign pin_override_out = enable;
  assign flush            = !enable;

  // Bits are taken on the rate strobe or on the external clock edge
  assign bit_strobe = cfg_in.sync_mode ? xck_rise : sample_tick_in;

  // In sync mode a low line at the clock edge is the start bit
  assign start_seen = cfg_in.sync_mode ? (xck_rise && !rx_level) : start_valid_in;
  assign start_take = enable && (state_q == uart_rx_pkg::ST_IDLE) && start_seen;

  // Buffer full and a character still parked in the shifter
  assign ovr_event = start_take && hold_q && !fifo_ready;

  // ----------------------------------------------------------------
  // Frame sequencer
  // ----------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      uart_rx_pkg::ST_IDLE: begin
        if (start_take) begin
          state_d = uart_rx_pkg::ST_DATA;
        end
      end
      uart_rx_pkg::ST_DATA: begin
        if (bit_strobe && (bit_cnt_q == frame_bits_q - 4'h1)) begin
          state_d = par_en_q ? uart_rx_pkg::ST_PARITY : uart_rx_pkg::ST_STOP;
        end
      end
      uart_rx_pkg::ST_PARITY: begin
        if (bit_strobe) begin
          state_d = uart_rx_pkg::ST_STOP;
        end
      end
      uart_rx_pkg::ST_STOP: begin
        // Back to idle after the first stop bit; a second one is never sampled
        if (bit_strobe) begin
          state_d = uart_rx_pkg::ST_IDLE;
        end
      end
    endcase
    if (!enable) begin
      state_d = uart_rx_pkg::ST_IDLE;
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state_q <= uart_rx_pkg::ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  assign stop_take = enable && (state_q == uart_rx_pkg::ST_STOP) && bit_strobe;
  assign capture   = stop_take && !discard_q;
  assign rx_busy_out = (state_q != uart_rx_pkg::ST_IDLE);

  // ----------------------------------------------------------------
  // Frame format latched at start
  // ----------------------------------------------------------------
  // Latching keeps a mid-frame setting change from splitting a frame
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      frame_bits_q <= uart_rx_pkg::BITS_EIGHT;
      par_en_q     <= uart_rx_pkg::FLAG_RST;
      par_odd_q    <= uart_rx_pkg::FLAG_RST;
      discard_q    <= uart_rx_pkg::FLAG_RST;
    end else if (start_take) begin
      frame_bits_q <= uart_rx_pkg::char_bits(cfg_in.char_size_select);
      par_en_q     <= cfg_in.parity_enable;
      par_odd_q    <= cfg_in.parity_odd_select;
      discard_q    <= ovr_event;
    end
  end

  // ----------------------------------------------------------------
  // Shift register and bit counter
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      shift_q   <= uart_rx_pkg::SHIFT_RST;
      bit_cnt_q <= uart_rx_pkg::CNT_RST;
    end else if (start_take || !enable) begin
      shift_q   <= uart_rx_pkg::SHIFT_RST;
      bit_cnt_q <= uart_rx_pkg::CNT_RST;
    end else if ((state_q == uart_rx_pkg::ST_DATA) && bit_strobe) begin
      shift_q   <= {rx_level, shift_q[8:1]};
      bit_cnt_q <= bit_cnt_q + 4'h1;
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      par_bit_q <= uart_rx_pkg::FLAG_RST;
    end else if ((state_q == uart_rx_pkg::ST_PARITY) && bit_strobe) begin
      par_bit_q <= rx_level;
    end
  end

  // LSB-first bits pile up at the top; right-align clears unused bits
  assign aligned = shift_q >> (uart_rx_pkg::BITS_NINE - frame_bits_q);

  // Even parity expects a zero sum, odd parity a one
  assign par_err = par_en_q && ((^aligned ^ par_bit_q) != par_odd_q);

  // ----------------------------------------------------------------
  // Holding stage between shifter and buffer
  // ----------------------------------------------------------------
  // The held word stands for the shifter contents while the buffer is full
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      hold_q <= uart_rx_pkg::FLAG_RST;
    end else if (!enable) begin
      hold_q <= uart_rx_pkg::FLAG_RST;
    end else if (capture) begin
      hold_q <= 1'b1;
    end else if (push) begin
      hold_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      hold_word_q <= '0;
    end else if (capture) begin
      hold_word_q.data       <= aligned & uart_rx_pkg::DATA_ONES;
      hold_word_q.frame_err  <= !rx_level;
      hold_word_q.overrun    <= 1'b0;
      hold_word_q.parity_err <= par_err;
    end
  end

  // Lost frames are reported on the next word to enter the buffer
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      pend_ovr_q <= uart_rx_pkg::FLAG_RST;
    end else if (!enable) begin
      pend_ovr_q <= uart_rx_pkg::FLAG_RST;
    end else if (ovr_event) begin
      pend_ovr_q <= 1'b1;
    end else if (push) begin
      pend_ovr_q <= 1'b0;
    end
  end

  always_comb begin
    push_word         = hold_word_q;
    push_word.overrun = pend_ovr_q;
  end

  assign push = hold_q && fifo_ready && enable;

  // ----------------------------------------------------------------
  // Receive buffer
  // ----------------------------------------------------------------
  rx_fifo #(
    .WIDTH (uart_rx_pkg::RX_WORD_W),
    .DEPTH (uart_rx_pkg::RX_BUF_DEPTH)
  ) u_rx_buf (
    .clk_in        (clk_in),
    .rstn_in       (rstn_in),
    .flush_in      (flush),
    .in_valid_in   (hold_q && enable),
    .in_ready_out  (fifo_ready),
    .in_data_in    (push_word),
    .out_valid_out (fifo_valid),
    .out_ready_in  (data_read_in),
    .out_data_out  (fifo_out)
  );

  assign head_word = uart_rx_pkg::rx_word_t'(fifo_out);

  // ----------------------------------------------------------------
  // Processor view
  // ----------------------------------------------------------------
  // Status and ninth bit belong to the head frame; a data read moves on
  assign rx_data_port_out      = head_word.data[7:0];
  assign rx_ninth_bit_out      = head_word.data[8];
  assign frame_error_flag_out  = fifo_valid && head_word.frame_err;
  assign overrun_flag_out      = fifo_valid && head_word.overrun;
  assign parity_error_flag_out = fifo_valid && head_word.parity_err;
  assign rx_complete_flag_out  = fifo_valid;

  // Only the complete flag reaches the request line
  assign rx_complete_irq_out = fifo_valid
                            && cfg_in.rx_complete_irq_enable
                            && global_irq_enable_in;

endmodule

//--- hdl/uart_rx_pkg.sv
// Purpose: Shared constants, types and helpers of the serial receive path
// Assumes: 10 MHz system clock, frames sent LSB first
// Notes:   Buffer depth follows the two-character receive buffer
package uart_rx_pkg;

  // ----------------------------------------------------------------
  // Buffer shape
  // ----------------------------------------------------------------
  localparam int RX_BUF_DEPTH = 2;
  localparam int RX_WORD_W    = 12;

  // ----------------------------------------------------------------
  // Character size codes and bit counts
  // ----------------------------------------------------------------
  localparam logic [2:0] SIZE_NINE  = 3'h7;
  localparam logic [3:0] BITS_BASE  = 4'h5;
  localparam logic [3:0] BITS_EIGHT = 4'h8;
  localparam logic [3:0] BITS_NINE  = 4'h9;
  localparam logic [8:0] DATA_ONES  = 9'h1FF;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [3:0] CNT_RST   = 4'h0;
  localparam logic [8:0] SHIFT_RST = 9'h000;
  localparam logic       FLAG_RST  = 1'b0;
  localparam logic       LEVEL_RST = 1'b1;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_DATA   = 2'b01,
    ST_PARITY = 2'b10,
    ST_STOP   = 2'b11
  } rx_state_t;

  typedef struct packed {
    logic [8:0] data;
    logic       frame_err;
    logic       overrun;
    logic       parity_err;
  } rx_word_t;

  typedef struct packed {
    logic       receiver_enable;
    logic       sync_mode;
    logic [2:0] char_size_select;
    logic       parity_enable;
    logic       parity_odd_select;
    logic       rx_complete_irq_enable;
  } rx_cfg_t;

  // Data bits per character; reserved codes fall back to eight
  function automatic logic [3:0] char_bits(input logic [2:0] size);
    logic [3:0] n;
    n = BITS_EIGHT;
    if (size == SIZE_NINE) begin
      n = BITS_NINE;
    end else if (size[2] == 1'b0) begin
      n = BITS_BASE + {2'b00, size[1:0]};
    end
    return n;
  endfunction

endpackage

//--- hdl/rx_pin_sync.sv
// Purpose: Three-stage synchroniser with agreement filter for one pin
// Assumes: Pin is asynchronous to clk_in
// Notes:   Level changes only when the second and third stages agree
`timescale 1ns/1ps
module rx_pin_sync (
  // Clock and reset
  input  wire logic clk_in,
  input  wire logic rstn_in,
  // Pin side
  input  wire logic pin_in,
  // Filtered view
  output logic      level_out,
  output logic      rise_out
);

  logic s1_q;
  logic s2_q;
  logic s3_q;
  logic level_q;
  logic rise_q;

  // First stage is read by the second stage only
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      s1_q <= uart_rx_pkg::LEVEL_RST;
      s2_q <= uart_rx_pkg::LEVEL_RST;
      s3_q <= uart_rx_pkg::LEVEL_RST;
    end else begin
      s1_q <= pin_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      level_q <= uart_rx_pkg::LEVEL_RST;
      rise_q  <= uart_rx_pkg::FLAG_RST;
    end else begin
      rise_q <= (s2_q == s3_q) && s3_q && !level_q;
      if (s2_q == s3_q) begin
        level_q <= s3_q;
      end
    end
  end

  assign level_out = level_q;
  assign rise_out  = rise_q;

endmodule

//--- hdl/rx_fifo.sv
// Purpose: Flip-flop FIFO with valid/ready on both sides and flush
// Assumes: Single clock; flush has priority over push and pop
// Notes:   Head word is a flop read through an index
`timescale 1ns/1ps
module rx_fifo #(
  parameter int WIDTH = uart_rx_pkg::RX_WORD_W,
  parameter int DEPTH = uart_rx_pkg::RX_BUF_DEPTH
) (
  // Clock and reset
  input  wire logic             clk_in,
  input  wire logic             rstn_in,
  input  wire logic             flush_in,
  // Fill side
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  input  wire logic [WIDTH-1:0] in_data_in,
  // Drain side
  output logic                  out_valid_out,
  input  wire logic             out_ready_in,
  output logic      [WIDTH-1:0] out_data_out
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_q;
  logic [AW-1:0]    rd_q;
  logic [AW:0]      cnt_q;
  logic             push;
  logic             pop;

  assign in_ready_out  = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid_out = (cnt_q != '0);
  assign push          = in_valid_in && in_ready_out;
  assign pop           = out_valid_out && out_ready_in;
  assign out_data_out  = mem_q[rd_q];

  always_ff @(posedge clk_in) begin
    if (push) begin
      mem_q[wr_q] <= in_data_in;
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else if (flush_in) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + AW'(1);
      end
      if (pop) begin
        rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + AW'(1);
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

endmodule

//--- tb/uart_rx_status_chk.sv
// Purpose: Port-level assertions for the serial receive buffer and status
// Assumes: Single clock, asynchronous active-low reset
// Notes:   Sees only the top module's ports
`timescale 1ns/1ps
module uart_rx_status_chk (
  // Clock and reset
  input wire logic                 clk_in,
  input wire logic                 rstn_in,
  // Configuration and processor side
  input wire uart_rx_pkg::rx_cfg_t cfg_in,
  input wire logic                 global_irq_enable_in,
  input wire logic                 data_read_in,
  input wire logic [7:0]           rx_data_port_out,
  input wire logic                 rx_ninth_bit_out,
  input wire logic                 frame_error_flag_out,
  input wire logic                 overrun_flag_out,
  input wire logic                 parity_error_flag_out,
  input wire logic                 rx_complete_flag_out,
  input wire logic                 rx_complete_irq_out,
  input wire logic                 pin_override_out,
  input wire logic                 rx_busy_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rstn_in);

  irq_level_a: assert property (
    rx_complete_irq_out == (rx_complete_flag_out && cfg_in.rx_complete_irq_enable
                            && global_irq_enable_in)) else $error("irq level wrong");
  irq_needs_data_a: assert property (
    rx_complete_irq_out |-> rx_complete_flag_out) else $error("irq without data");
  pin_owner_a: assert property (
    pin_override_out == cfg_in.receiver_enable) else $error("pin owner wrong");
  disable_flush_a: assert property (
    !cfg_in.receiver_enable |=> !rx_complete_flag_out) else $error("no flush");
  disable_abort_a: assert property (
    !cfg_in.receiver_enable |=> !rx_busy_out) else $error("no abort");
  head_hold_a: assert property (
    rx_complete_flag_out && !data_read_in && cfg_in.receiver_enable |=>
      $stable({rx_ninth_bit_out, rx_data_port_out, frame_error_flag_out,
               overrun_flag_out, parity_error_flag_out})) else $error("head moved");
  empty_clean_a: assert property (
    !rx_complete_flag_out |-> !(frame_error_flag_out || overrun_flag_out
                                || parity_error_flag_out)) else $error("flags when empty");
  push_after_stop_a: assert property (
    $rose(rx_complete_flag_out) |-> $past(rx_busy_out, 2)) else $error("push late");
endmodule

bind uart_receive_buffer_status uart_rx_status_chk i_chk (
  .clk_in               (clk_in),
  .rstn_in              (rstn_in),
  .cfg_in               (cfg_in),
  .global_irq_enable_in (global_irq_enable_in),
  .data_read_in         (data_read_in),
  .rx_data_port_out     (rx_data_port_out),
  .rx_ninth_bit_out     (rx_ninth_bit_out),
  .frame_error_flag_out (frame_error_flag_out),
  .overrun_flag_out     (overrun_flag_out),
  .parity_error_flag_out(parity_error_flag_out),
  .rx_complete_flag_out (rx_complete_flag_out),
  .rx_complete_irq_out  (rx_complete_irq_out),
  .pin_override_out     (pin_override_out),
  .rx_busy_out          (rx_busy_out)
);

//--- tb/uart_rx_sender.sv
// Purpose: Remote serial transmitter with start qualifier and mid-bit strobes
// Assumes: Line idles high between frames
// Notes:   Strobes sit mid-bit so the receiver's synchroniser lag is covered
`timescale 1ns/1ps
module uart_rx_sender #(
  parameter int BIT_CYC = 16
) (
  input  wire logic clk_in,
  output logic      pin_out,
  output logic      start_out,
  output logic      tick_out,
  output logic      xck_out
);
  initial begin
    pin_out   = 1'b1;
    start_out = 1'b0;
    tick_out  = 1'b0;
    xck_out   = 1'b0;
  end

  task automatic put_bit(input logic b, input logic is_start);
    @(posedge clk_in) #1;
    pin_out = b;
    xck_out = 1'b0;
    repeat (BIT_CYC / 2) @(posedge clk_in);
    #1;
    // Clock stays high half a bit so the receiver's filter keeps the edge
    xck_out = 1'b1;
    if (is_start) begin
      start_out = 1'b1;
    end else begin
      tick_out = 1'b1;
    end
    @(posedge clk_in) #1;
    start_out = 1'b0;
    tick_out  = 1'b0;
    repeat (BIT_CYC / 2 - 2) @(posedge clk_in);
  endtask

  // One stop bit only; idle high follows at once
  task automatic send(input logic [8:0] data, input int nbits, input logic par_on,
                      input logic par_bit, input logic stop_bit);
    put_bit(1'b0, 1'b1);
    for (int i = 0; i < nbits; i++) begin
      put_bit(data[i], 1'b0);
    end
    if (par_on) begin
      put_bit(par_bit, 1'b0);
    end
    put_bit(stop_bit, 1'b0);
    @(posedge clk_in) #1;
    pin_out = 1'b1;
    xck_out = 1'b0;
  endtask
endmodule

//--- tb/uart_receive_buffer_status_tb_top.sv
// Purpose: Self-checking bench for the serial receive buffer and status
// Assumes: Strobes and external sync clock supplied by the sender model
// Notes:   Sync clock stands still between frames
`timescale 1ns/1ps
module uart_receive_buffer_status_tb_top;
  logic                 clk_in;
  logic                 rstn_in;
  uart_rx_pkg::rx_cfg_t cfg;
  logic                 global_irq_enable;
  logic                 data_read;
  logic                 rx_pin;
  logic                 start_valid;
  logic                 sample_tick;
  logic                 ext_sync_clock;
  logic [7:0]           rx_data_port;
  logic                 rx_ninth_bit;
  logic                 frame_error_flag;
  logic                 overrun_flag;
  logic                 parity_error_flag;
  logic                 rx_complete_flag;
  logic                 rx_complete_irq;
  logic                 pin_override;
  logic                 rx_busy;
  int                   errors;
  int                   samples_checked;
  logic [2:0]           sizes [8] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h7, 3'h4, 3'h5, 3'h6};
  logic [8:0]           d;
  logic                 p;
  int                   nb;

  initial begin
    clk_in = 1'b0;
    forever #50 clk_in = ~clk_in;
  end

  uart_rx_sender i_sender (
    .clk_in   (clk_in),
    .pin_out  (rx_pin),
    .start_out(start_valid),
    .tick_out (sample_tick),
    .xck_out  (ext_sync_clock)
  );

  uart_receive_buffer_status i_dut (
    .clk_in               (clk_in),
    .rstn_in              (rstn_in),
    .cfg_in               (cfg),
    .global_irq_enable_in (global_irq_enable),
    .rx_pin_in            (rx_pin),
    .ext_sync_clock_in    (ext_sync_clock),
    .start_valid_in       (start_valid),
    .sample_tick_in       (sample_tick),
    .data_read_in         (data_read),
    .rx_data_port_out     (rx_data_port),
    .rx_ninth_bit_out     (rx_ninth_bit),
    .frame_error_flag_out (frame_error_flag),
    .overrun_flag_out     (overrun_flag),
    .parity_error_flag_out(parity_error_flag),
    .rx_complete_flag_out (rx_complete_flag),
    .rx_complete_irq_out  (rx_complete_irq),
    .pin_override_out     (pin_override),
    .rx_busy_out          (rx_busy)
  );

  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  function automatic int bits_of(input logic [2:0] s);
    return (s == 3'h7) ? 9 : (s[2] ? 8 : 5 + int'(s[1:0]));
  endfunction

  // Status and ninth bit are taken before the data read pops the head
  task automatic read_word(input logic [8:0] exp_data, input logic [2:0] exp_flags);
    int n;
    n = 0;
    while (rx_complete_flag !== 1'b1 && n < 400) begin
      @(posedge clk_in) #1;
      n++;
    end
    check(rx_complete_flag, 1'b1, "complete flag");
    check({frame_error_flag, overrun_flag, parity_error_flag}, exp_flags, "flags");
    check({rx_ninth_bit, rx_data_port}, exp_data, "data");
    @(posedge clk_in) #1;
    data_read = 1'b1;
    @(posedge clk_in) #1;
    data_read = 1'b0;
  endtask

  task automatic end_of_test();
    if (errors == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk_in);
    errors++;
    end_of_test();
  end

  initial begin
    errors = 0;
    samples_checked = 0;
    rstn_in = 1'b0;
    cfg = '0;
    cfg.receiver_enable = 1'b1;
    cfg.rx_complete_irq_enable = 1'b1;
    global_irq_enable = 1'b1;
    data_read = 1'b0;
    repeat (10) @(posedge clk_in);
    #1;
    rstn_in = 1'b1;
    repeat (5) @(posedge clk_in);
    // Every size code, all-ones data shows the masking
    foreach (sizes[i]) begin
      cfg.char_size_select = sizes[i];
      nb = bits_of(sizes[i]);
      i_sender.send(9'h1FF, nb, 1'b0, 1'b0, 1'b1);
      check(rx_complete_irq, 1'b1, "irq on");
      global_irq_enable = 1'b0;
      #1;
      check(rx_complete_irq, 1'b0, "irq masked");
      global_irq_enable = 1'b1;
      read_word(9'h1FF >> (9 - nb), 3'b000);
    end
    check({rx_complete_flag, rx_complete_irq}, 2'b00, "empty after read");
    cfg.char_size_select = 3'h3;
    // Even and odd parity, right and wrong
    for (int k = 0; k < 4; k++) begin
      cfg.parity_enable = 1'b1;
      cfg.parity_odd_select = k[0];
      d = 9'h0A5 ^ 9'(k);
      p = ^d[7:0] ^ k[0] ^ k[1];
      i_sender.send(d, 8, 1'b1, p, 1'b1);
      read_word({1'b0, d[7:0]}, {2'b00, k[1]});
    end
    cfg.parity_enable = 1'b0;
    // Bad stop then good stop, back to back
    i_sender.send(9'h055, 8, 1'b0, 1'b0, 1'b0);
    i_sender.send(9'h0AA, 8, 1'b0, 1'b0, 1'b1);
    read_word(9'h055, 3'b100);
    read_word(9'h0AA, 3'b000);
    // Two buffered, one held, fourth start overruns and is lost
    i_sender.send(9'h011, 8, 1'b0, 1'b0, 1'b1);
    i_sender.send(9'h022, 8, 1'b0, 1'b0, 1'b1);
    i_sender.send(9'h033, 8, 1'b0, 1'b0, 1'b1);
    i_sender.send(9'h044, 8, 1'b0, 1'b0, 1'b1);
    read_word(9'h011, 3'b000);
    read_word(9'h022, 3'b000);
    read_word(9'h033, 3'b010);
    check(rx_complete_flag, 1'b0, "lost frame absent");
    i_sender.send(9'h055, 8, 1'b0, 1'b0, 1'b1);
    read_word(9'h055, 3'b000);
    // Synchronous mode: bits taken on the external clock's rising edge
    cfg.sync_mode = 1'b1;
    i_sender.send(9'h03C, 8, 1'b0, 1'b0, 1'b0);
    i_sender.send(9'h0C3, 8, 1'b0, 1'b0, 1'b1);
    read_word(9'h03C, 3'b100);
    read_word(9'h0C3, 3'b000);
    cfg.sync_mode = 1'b0;
    // Disable flushes the buffer and frees the pin
    i_sender.send(9'h066, 8, 1'b0, 1'b0, 1'b1);
    cfg.receiver_enable = 1'b0;
    @(posedge clk_in) #1;
    check({rx_complete_flag, pin_override}, 2'b00, "flushed");
    cfg.receiver_enable = 1'b1;
    #1;
    check(pin_override, 1'b1, "pin taken");
    // Disable in mid-frame abandons it
    fork
      i_sender.send(9'h077, 8, 1'b0, 1'b0, 1'b1);
    join_none
    repeat (60) @(posedge clk_in);
    #1;
    check(rx_busy, 1'b1, "busy mid-frame");
    cfg.receiver_enable = 1'b0;
    @(posedge clk_in) #1;
    check(rx_busy, 1'b0, "aborted");
    wait fork;
    cfg.receiver_enable = 1'b1;
    repeat (5) @(posedge clk_in);
    #1;
    check(rx_complete_flag, 1'b0, "nothing stored");
    end_of_test();
  end
endmodule
